/* design/pmwc_power_ctrl.sv */
// Behaviour
// - run from internal RC after power-up/power-down
// - wake-up timer flags oscillator safe
// - timer check on reset and oscillator off
// - power-down stops oscillator, wake restarts timer
// - sleep, deep-sleep, power-down, deep power-down
// - cpu rate via source and divider
// - per-peripheral clock enable
// - each peripheral has own divider
// - regulator level follows mode automatically
// - always-on rtc and retained registers
// - sleep stops core clock
// - sleep exit only re-enables core clock
// - sleep held until reset or interrupt
// - peripherals run and wake in sleep
// - pin interrupts on rise, fall, both
module pmwc_power_ctrl (
    // system
    input wire logic clock,
    input wire logic arst_n,
    // software control
    input wire pmwc_pkg::pmwc_ctrl_t ctrl,
    input wire logic [pmwc_pkg::DIV_W-1:0] perDiv [pmwc_pkg::NUM_PERIPH],
    input wire pmwc_pkg::pmwc_edge_t edgeCfg,
    input wire logic retainWrite,
    input wire logic [pmwc_pkg::RETAIN_W-1:0] retainData,
    // events
    input wire logic irqIn,
    input wire logic [pmwc_pkg::IRQ_PINS-1:0] pinIn,
    input wire logic oscTick,
    input wire logic rtcTick,
    // status and clock gates
    output pmwc_pkg::pmwc_mode_t mode,
    output pmwc_pkg::pmwc_src_t srcActive,
    output logic oscPowerOn,
    output logic oscStable,
    output logic coreClkEn,
    output logic cpuTick,
    output logic [pmwc_pkg::NUM_PERIPH-1:0] perTick,
    output logic [2:0] regLevel,
    output logic [pmwc_pkg::IRQ_PINS-1:0] pinIrq,
    output logic [31:0] rtcCount,
    output logic [pmwc_pkg::RETAIN_W-1:0] retainReg
);

    ////////////////////////////////////////////////////////////////////////
    // pin edge interrupts

    logic [pmwc_pkg::IRQ_PINS-1:0] pinLast;
    logic wakeEvent;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinLast <= '0;
            pinIrq <= '0;
        end
        else
        begin
            pinLast <= pinIn;
            pinIrq <= (pinIn & ~pinLast & edgeCfg.riseEn)
                | (~pinIn & pinLast & edgeCfg.fallEn);
        end
    end

    // pin edges wake the core like any peripheral interrupt
    assign wakeEvent = irqIn | (|pinIrq);

    ////////////////////////////////////////////////////////////////////////
    // mode sequencing

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mode <= pmwc_pkg::PM_RUN;
        else
        begin
            case (mode)
                pmwc_pkg::PM_RUN:
                    if (ctrl.modeGo)
                        mode <= ctrl.modeReq;
                pmwc_pkg::PM_SLEEP,
                pmwc_pkg::PM_DEEPSLEEP,
                pmwc_pkg::PM_PWRDOWN:
                    if (wakeEvent)
                        mode <= pmwc_pkg::PM_RUN;
                pmwc_pkg::PM_DEEPPD:
                    // only a reset leaves deep power-down
                    mode <= pmwc_pkg::PM_DEEPPD;
                default:
                    mode <= pmwc_pkg::PM_RUN;
            endcase
        end
    end

    // core clock gated in every reduced mode; plain re-enable on wake
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            coreClkEn <= 1'b1;
        else
            coreClkEn <= (mode == pmwc_pkg::PM_RUN) && !(ctrl.modeGo
                && ctrl.modeReq != pmwc_pkg::PM_RUN);
    end

    // regulator setting tracks mode with no software step
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            regLevel <= pmwc_pkg::REG_RUN;
        else
            regLevel <= mode;
    end

    ////////////////////////////////////////////////////////////////////////
    // oscillator and wake-up timer

    logic oscOff;
    logic [pmwc_pkg::WUT_W-1:0] wutCnt;

    assign oscOff = (mode == pmwc_pkg::PM_PWRDOWN) || (mode == pmwc_pkg::PM_DEEPPD)
        || (mode == pmwc_pkg::PM_DEEPSLEEP) || !ctrl.oscEnable;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            oscPowerOn <= 1'b0;
        else
            oscPowerOn <= !oscOff;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wutCnt <= '0;
            oscStable <= 1'b0;
        end
        else if (oscOff)
        begin
            wutCnt <= '0;
            oscStable <= 1'b0;
        end
        else if (oscTick && !oscStable)
        begin
            wutCnt <= wutCnt + 1'b1;
            if (wutCnt + 1'b1 >= ctrl.wutCount)
                oscStable <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // clock source and cpu divider

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            srcActive <= pmwc_pkg::SRC_RCOSC;
        else if (oscOff || !oscStable)
            srcActive <= pmwc_pkg::SRC_RCOSC;
        else
            // ctrl.srcSel takes over again without a software step once the oscillator is stable
            srcActive <= ctrl.srcSel;
    end

    logic [pmwc_pkg::DIV_W-1:0] cpuCnt;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cpuCnt <= '0;
            cpuTick <= 1'b0;
        end
        else if (!coreClkEn)
        begin
            cpuCnt <= '0;
            cpuTick <= 1'b0;
        end
        else if (cpuCnt + 1'b1 >= ctrl.cpuDiv)
        begin
            cpuCnt <= '0;
            cpuTick <= 1'b1;
        end
        else
        begin
            cpuCnt <= cpuCnt + 1'b1;
            cpuTick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // peripheral clock gates and dividers

    logic perRun;

    // peripherals stay clocked in run and sleep only
    assign perRun = (mode == pmwc_pkg::PM_RUN) || (mode == pmwc_pkg::PM_SLEEP);

    genvar p;
    generate
        for (p = 0; p < pmwc_pkg::NUM_PERIPH; p++)
        begin : g_per
            logic [pmwc_pkg::DIV_W-1:0] cnt;
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    cnt <= '0;
                    perTick[p] <= 1'b0;
                end
                else if (!ctrl.perEnable[p] || !perRun)
                begin
                    cnt <= '0;
                    perTick[p] <= 1'b0;
                end
                else if (cnt + 1'b1 >= perDiv[p])
                begin
                    cnt <= '0;
                    perTick[p] <= 1'b1;
                end
                else
                begin
                    cnt <= cnt + 1'b1;
                    perTick[p] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // always-on domain: not cleared by mode, only by reset

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rtcCount <= '0;
        else if (rtcTick)
            rtcCount <= rtcCount + 32'h0000_0001;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            retainReg <= '0;
        else if (retainWrite)
            retainReg <= retainData;
    end

endmodule

/* design/pmwc_pkg.sv */
package pmwc_pkg;

    // power modes
    typedef enum logic [2:0] {
        PM_RUN       = 3'b000,
        PM_SLEEP     = 3'b001,
        PM_DEEPSLEEP = 3'b010,
        PM_PWRDOWN   = 3'b011,
        PM_DEEPPD    = 3'b100
    } pmwc_mode_t;

    // clock source selection
    typedef enum logic [1:0] {
        SRC_RCOSC = 2'b00,
        SRC_MAIN = 2'b01,
        SRC_PLL  = 2'b10
    } pmwc_src_t;

    localparam int NUM_PERIPH = 8;
    localparam int DIV_W = 8;
    localparam int WUT_W = 16;
    localparam int RETAIN_W = 32;
    localparam int IRQ_PINS = 16;
    localparam int RC_FREQ_MHZ = 12;

    localparam logic [DIV_W-1:0] CPU_DIV_RESET = 8'h01;
    localparam logic [DIV_W-1:0] PER_DIV_RESET = 8'h01;
    localparam logic [WUT_W-1:0] WUT_COUNT_RESET = 16'h1000;
    localparam logic [2:0] REG_RUN = 3'h0;

    // software control bundle
    typedef struct packed {
        pmwc_mode_t modeReq;
        logic modeGo;
        logic oscEnable;
        pmwc_src_t srcSel;
        logic [DIV_W-1:0] cpuDiv;
        logic [NUM_PERIPH-1:0] perEnable;
        logic [WUT_W-1:0] wutCount;
    } pmwc_ctrl_t;

    // pin interrupt configuration
    typedef struct packed {
        logic [IRQ_PINS-1:0] riseEn;
        logic [IRQ_PINS-1:0] fallEn;
    } pmwc_edge_t;

endpackage

/* sim/pmwc_power_ctrl_asserts.sv */
module pmwc_power_ctrl_asserts (
    // clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // watched ports
    input wire pmwc_pkg::pmwc_ctrl_t ctrl,
    input wire logic irqIn,
    input wire pmwc_pkg::pmwc_mode_t mode,
    input wire pmwc_pkg::pmwc_src_t srcActive,
    input wire logic oscPowerOn,
    input wire logic oscStable,
    input wire logic coreClkEn,
    input wire logic [2:0] regLevel,
    input wire logic [pmwc_pkg::IRQ_PINS-1:0] pinIrq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    // srcActive is registered, so judge against last cycle's stable flag
    a_irc_unstable: assert property (
        !$past(oscStable) |-> srcActive == pmwc_pkg::SRC_RCOSC) else $error("source not rc");
    a_sleep_gate: assert property (
        mode == pmwc_pkg::PM_SLEEP |-> !coreClkEn) else $error("core clock on in sleep");
    a_sleep_wake: assert property (
        mode == pmwc_pkg::PM_SLEEP && irqIn |=> mode == pmwc_pkg::PM_RUN ##1 coreClkEn)
        else $error("sleep wake slow");
    a_sleep_hold: assert property (
        mode == pmwc_pkg::PM_SLEEP && !irqIn && pinIrq == '0 |=> mode == pmwc_pkg::PM_SLEEP)
        else $error("sleep left early");
    a_reg_follow: assert property (
        mode != pmwc_pkg::PM_RUN |=> regLevel == $past(mode)) else $error("regulator stale");
    a_pd_osc_off: assert property (
        mode == pmwc_pkg::PM_PWRDOWN ##1 mode == pmwc_pkg::PM_PWRDOWN |-> !oscPowerOn)
        else $error("osc on in power-down");
    a_go_mode: assert property (
        mode == pmwc_pkg::PM_RUN && ctrl.modeGo |=> mode == $past(ctrl.modeReq))
        else $error("mode request lost");
    a_off_unstable: assert property (
        !oscPowerOn |=> !oscStable) else $error("stable while osc off");
    a_deeppd_stay: assert property (
        mode == pmwc_pkg::PM_DEEPPD |=> mode == pmwc_pkg::PM_DEEPPD) else $error("deep pd left");
endmodule
bind pmwc_power_ctrl pmwc_power_ctrl_asserts pmwc_power_ctrl_asserts_i (.clock(clock),
    .arst_n(arst_n), .ctrl(ctrl), .irqIn(irqIn), .mode(mode), .srcActive(srcActive),
    .oscPowerOn(oscPowerOn), .oscStable(oscStable), .coreClkEn(coreClkEn),
    .regLevel(regLevel), .pinIrq(pinIrq));

/* sim/pmwc_osc_model.sv */
module pmwc_osc_model (
    // clock and power
    input wire logic clock,
    input wire logic oscPowerOn,
    // crystal
    output logic oscTick
);
    timeunit 1ns;
    timeprecision 1ns;
    // half-rate crystal; no ticks at all while unpowered
    initial oscTick = 1'h0;
    always @(posedge clock)
    begin
        oscTick <= #2 oscPowerOn && !oscTick;
    end
endmodule

/* sim/pmwc_power_ctrl_tb.sv */
module pmwc_power_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock, arst_n, irqIn, oscTick, oscPowerOn, oscStable, coreClkEn;
    pmwc_pkg::pmwc_ctrl_t ctrl;
    pmwc_pkg::pmwc_edge_t edgeCfg;
    logic [pmwc_pkg::DIV_W-1:0] perDiv [pmwc_pkg::NUM_PERIPH];
    logic [pmwc_pkg::IRQ_PINS-1:0] pinIn, pinIrq;
    pmwc_pkg::pmwc_mode_t mode;
    pmwc_pkg::pmwc_src_t srcActive;
    logic [pmwc_pkg::NUM_PERIPH-1:0] perTick;
    logic [2:0] regLevel;
    logic cpuTick, rtcTick, retainWrite;
    logic [31:0] rtcCount, retainReg, retainData;
    int n_mismatch, comparisons;
    pmwc_power_ctrl pmwc_power_ctrl_i (.clock(clock), .arst_n(arst_n), .ctrl(ctrl),
        .perDiv(perDiv), .edgeCfg(edgeCfg), .retainWrite(retainWrite), .retainData(retainData),
        .irqIn(irqIn), .pinIn(pinIn), .oscTick(oscTick), .rtcTick(rtcTick), .mode(mode),
        .srcActive(srcActive), .oscPowerOn(oscPowerOn), .oscStable(oscStable),
        .coreClkEn(coreClkEn), .cpuTick(cpuTick), .perTick(perTick), .regLevel(regLevel),
        .pinIrq(pinIrq), .rtcCount(rtcCount), .retainReg(retainReg));
    pmwc_osc_model pmwc_osc_model_i (.clock(clock), .oscPowerOn(oscPowerOn), .oscTick(oscTick));
    ////////////////////////////////////////
    task end_sim;
        if (n_mismatch == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    // inputs move 2 ns after the edge so sampling never races
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    task go(input pmwc_pkg::pmwc_mode_t m);
        ctrl.modeReq = m;
        ctrl.modeGo = 1'h1;
        cyc(1);
        ctrl.modeGo = 1'h0;
    endtask
    task wait_stable;
        for (int i = 0; i < 100 && oscStable !== 1'h1; i++)
            cyc(1);
        check("stable", 1, oscStable);
    endtask
    ////////////////////////////////////////
    task t_osc;
        check("src reset", pmwc_pkg::SRC_RCOSC, srcActive);
        ctrl.srcSel = pmwc_pkg::SRC_MAIN;
        ctrl.oscEnable = 1'h1;
        cyc(3);
        check("stable early", 0, oscStable);
        check("src early", pmwc_pkg::SRC_RCOSC, srcActive);
        wait_stable();
        cyc(1);
        check("src main", pmwc_pkg::SRC_MAIN, srcActive);
    endtask
    task t_sleep;
        go(pmwc_pkg::PM_SLEEP);
        check("core gated", 0, coreClkEn);
        cyc(3);
        check("sleep held", pmwc_pkg::PM_SLEEP, mode);
        check("regulator", pmwc_pkg::PM_SLEEP, regLevel);
        check("periph runs", 1, perTick[0]);
        irqIn = 1'h1;
        cyc(1);
        irqIn = 1'h0;
        check("sleep wake", pmwc_pkg::PM_RUN, mode);
        cyc(1);
        check("core back", 1, coreClkEn);
    endtask
    task t_pd;
        go(pmwc_pkg::PM_PWRDOWN);
        cyc(2);
        check("pd osc", 0, {oscPowerOn, oscStable});
        pinIn = 16'h0001;
        cyc(1);
        check("pin irq", 16'h0001, pinIrq);
        cyc(1);
        check("pin pulse", 16'h0000, pinIrq);
        check("pd wake", pmwc_pkg::PM_RUN, mode);
        check("pd src", pmwc_pkg::SRC_RCOSC, srcActive);
        pinIn = 16'h0000;
        wait_stable();
    endtask
    task t_div;
        int cpuN, per1N, per2N;
        cpuN = 0;
        per1N = 0;
        per2N = 0;
        ctrl.cpuDiv = 8'h02;
        perDiv[1] = 8'h03;
        ctrl.perEnable = 8'hFB;
        cyc(2);
        for (int i = 0; i < 12; i++)
        begin
            cyc(1);
            cpuN += cpuTick;
            per1N += perTick[1];
            per2N += perTick[2];
        end
        check("cpu div", 6, cpuN);
        check("per div", 4, per1N);
        check("per gate", 0, per2N);
        ctrl.cpuDiv = 8'h01;
        perDiv[1] = 8'h01;
        ctrl.perEnable = 8'hFF;
        rtcTick = 1'h1;
        retainWrite = 1'h1;
        retainData = 32'hA5A5_0F0F;
        cyc(1);
        rtcTick = 1'h0;
        retainWrite = 1'h0;
        check("rtc count", 1, rtcCount);
        check("retain", 32'hA5A5_0F0F, retainReg);
    endtask
    task t_deep;
        go(pmwc_pkg::PM_DEEPSLEEP);
        cyc(2);
        check("ds osc", 0, oscPowerOn);
        irqIn = 1'h1;
        cyc(1);
        check("ds wake", pmwc_pkg::PM_RUN, mode);
        go(pmwc_pkg::PM_DEEPPD);
        cyc(2);
        irqIn = 1'h0;
        check("deep pd", pmwc_pkg::PM_DEEPPD, mode);
        rtcTick = 1'h1;
        cyc(1);
        rtcTick = 1'h0;
        check("rtc in pd", 2, rtcCount);
        check("retain pd", 32'hA5A5_0F0F, retainReg);
        arst_n = 1'h0;
        cyc(1);
        arst_n = 1'h1;
        check("reset run", pmwc_pkg::PM_RUN, mode);
        check("reset stable", 0, oscStable);
    endtask
    ////////////////////////////////////////
    initial
    begin
        clock = 1'h0;
        forever #10 clock = ~clock;
    end
    initial
    begin
        #200000;
        n_mismatch++;
        end_sim();
    end
    initial
    begin
        arst_n = 1'h0;
        irqIn = 1'h0;
        pinIn = 16'h0000;
        rtcTick = 1'h0;
        retainWrite = 1'h0;
        retainData = 32'h0000_0000;
        ctrl = '0;
        ctrl.cpuDiv = 8'h01;
        ctrl.perEnable = 8'hFF;
        ctrl.wutCount = 16'h0004;
        edgeCfg = '0;
        edgeCfg.riseEn = 16'h0001;
        perDiv = '{default: 8'h01};
        cyc(16);
        arst_n = 1'h1;
        cyc(1);
        t_osc();
        t_sleep();
        t_pd();
        t_div();
        t_deep();
        end_sim();
    end
endmodule
